// file: design/carrier_phase_pkg.sv
package carrier_phase_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [4:0] ADDR_CARRIER_CONFIG    = 5'h01;
    localparam logic [4:0] ADDR_PROPORTIONAL_GAIN = 5'h02;
    localparam logic [4:0] ADDR_INTEGRAL_GAIN     = 5'h03;
    localparam logic [4:0] ADDR_SNR_THRESHOLD     = 5'h0b;
    localparam logic [4:0] ADDR_VCO_MEAS_LO       = 5'h0c;
    localparam logic [4:0] ADDR_VCO_MEAS_HI       = 5'h0d;
    localparam logic [4:0] ADDR_STATUS_FLAGS      = 5'h1f;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CFG_ESTIMATOR_SELECT = 2;
    localparam int CFG_PAIR1_ENABLE     = 4;
    localparam int CFG_PAIR2_ENABLE     = 5;
    localparam int CFG_MODULATION_BPSK  = 6;
    localparam int STAT_SNR_ABOVE       = 4;
    localparam int STAT_VCO_MEAS_FULL   = 0;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_CARRIER_CONFIG    = 8'h30;
    localparam logic [7:0] RST_PROPORTIONAL_GAIN = 8'h10;
    localparam logic [7:0] RST_INTEGRAL_GAIN     = 8'h20;
    localparam logic [7:0] RST_SNR_THRESHOLD     = 8'h64;

    // ****************************************
    // Data path constants
    // ****************************************
    localparam int SAMPLE_WIDTH = 8;
    localparam int PHASE_WIDTH  = 6;
    localparam int FIFO_DEPTH   = 32;
    localparam int SNR_SHIFT    = 4;

    typedef struct packed {
        logic signed [SAMPLE_WIDTH-1:0] i_val;
        logic signed [SAMPLE_WIDTH-1:0] q_val;
    } symbol_t;

    localparam int SYMBOL_WIDTH = 2 * SAMPLE_WIDTH;

    typedef struct packed {
        logic p1;
        logic n1;
        logic p2;
        logic n2;
    } sd_pairs_t;

endpackage

// file: design/symbol_fifo.sv
`timescale 1ns/10ps
module symbol_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_sys_rst,
    // Fill side
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_q;
    logic [AW:0]      rd_ptr_q;
    logic [AW:0]      wr_ptr_d;
    logic [AW:0]      rd_ptr_d;
    logic             in_ready_q;
    logic             push;
    logic             pop;

    assign o_in_ready  = in_ready_q;
    assign o_out_valid = wr_ptr_q != rd_ptr_q;
    assign o_out_data  = mem[rd_ptr_q[AW-1:0]];
    assign push        = i_in_valid && in_ready_q;
    assign pop         = o_out_valid && i_out_ready;
    assign wr_ptr_d    = wr_ptr_q + (AW+1)'(push);
    assign rd_ptr_d    = rd_ptr_q + (AW+1)'(pop);

    // Ready is registered from the fill level the next edge will leave
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            in_ready_q <= 1'b0;
        end else begin
            in_ready_q <= (wr_ptr_d - rd_ptr_d) != (AW+1)'(DEPTH);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem[wr_ptr_q[AW-1:0]] <= i_in_data;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            wr_ptr_q <= '0;
        end else if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            rd_ptr_q <= '0;
        end else if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
        end
    end
endmodule

// file: design/carrier_phase_tracking_loop.sv
`timescale 1ns/10ps
// What this block does
// [R1] VCO measurement held in 16-bit register until host reads both bytes
// [R2] QPSK mode offers non-data-aided and decision-directed estimators
// [R3] Config bit 2 picks decision-directed at 0, non-data-aided at 1
// [R4] BPSK mode always uses the decision-directed estimator
// [R5] SNR estimate compared to threshold at 11 picks detector gain
// [R6] Comparison result readable in status bit 4 at address 31
// [R7] Host should program the threshold with 100, about 11 dB
// [R8] Proportional and integral gain registers set loop dynamics
// [R9] Host should keep integral gain above 30 for 6-bit resolution
// [R10] Loop output leaves as two sigma-delta complementary pairs
// [R11] Config bits 4 and 5 enable each pair or float it
// [R12] After reset both pairs are driven
// [R13] Loop value before modulation appears on 6-bit parallel output
// [R14] Low baud rates should use the parallel output with a DAC
// [R15] Parallel output is stable relative to the data valid strobe
// [R16] Parallel output updates only when data valid is high
module carrier_phase_tracking_loop
    import carrier_phase_pkg::*;
#(
    parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                   i_mclk,
    input  wire logic                   i_sys_rst,
    // Register port
    input  wire logic [4:0]             i_reg_addr,
    input  wire logic [7:0]             i_reg_wdata,
    input  wire logic                   i_reg_wr,
    input  wire logic                   i_reg_rd,
    output logic      [7:0]             o_reg_rdata,
    // Symbol stream
    input  wire logic                   i_sym_valid,
    output logic                        o_sym_ready,
    input  wire symbol_t                i_sym,
    // VCO measurement
    input  wire logic                   i_vco_meas_valid,
    input  wire logic [15:0]            i_vco_meas,
    // Sigma-delta pairs
    output sd_pairs_t                   o_sd_out,
    output logic      [1:0]             o_sd_oe,
    // Parallel phase output
    output logic      [PHASE_WIDTH-1:0] o_parallel_phase_out,
    output logic                        o_data_valid
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [7:0]             carrier_configuration_q;
    logic [7:0]             proportional_gain_q;
    logic [7:0]             integral_gain_q;
    logic [7:0]             snr_threshold_q;
    logic [15:0]            vco_frequency_measure_q;
    logic                   vco_full_q;
    logic [1:0]             vco_read_q;
    logic                   snr_above_q;
    logic [15:0]            snr_acc_q;
    logic signed [15:0]     integ_q;
    logic signed [15:0]     loop_q;
    logic [PHASE_WIDTH:0]   sd1_acc_q;
    logic [PHASE_WIDTH:0]   sd2_acc_q;
    logic                   sd1_bit_q;
    logic                   sd2_bit_q;
    logic                   dv_q;
    logic                   fifo_valid;
    symbol_t                sym;
    logic signed [15:0]     ped_err;
    logic signed [15:0]     ped_scaled;
    logic                   sym_take;
    logic [PHASE_WIDTH-1:0] loop_code;

    // ****************************************
    // Input buffer
    // ****************************************
    symbol_fifo #(
        .WIDTH (SYMBOL_WIDTH),
        .DEPTH (FIFO_DEPTH_P)
    ) u_fifo (
        .i_mclk      (i_mclk),
        .i_sys_rst   (i_sys_rst),
        .i_in_valid  (i_sym_valid),
        .o_in_ready  (o_sym_ready),
        .i_in_data   (i_sym),
        .o_out_valid (fifo_valid),
        .i_out_ready (1'b1),
        .o_out_data  (sym)
    );

    assign sym_take = fifo_valid;

    // ****************************************
    // Register writes
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            carrier_configuration_q <= RST_CARRIER_CONFIG; // [R12]
            proportional_gain_q     <= RST_PROPORTIONAL_GAIN;
            integral_gain_q         <= RST_INTEGRAL_GAIN;
            snr_threshold_q         <= RST_SNR_THRESHOLD;
        end else if (i_reg_wr) begin
            unique case (i_reg_addr)
                ADDR_CARRIER_CONFIG:    carrier_configuration_q <= i_reg_wdata;
                ADDR_PROPORTIONAL_GAIN: proportional_gain_q     <= i_reg_wdata; // [R8]
                ADDR_INTEGRAL_GAIN:     integral_gain_q         <= i_reg_wdata; // [R8]
                ADDR_SNR_THRESHOLD:     snr_threshold_q         <= i_reg_wdata; // [R5]
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // Register reads
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            unique case (i_reg_addr)
                ADDR_CARRIER_CONFIG:    o_reg_rdata <= carrier_configuration_q;
                ADDR_PROPORTIONAL_GAIN: o_reg_rdata <= proportional_gain_q;
                ADDR_INTEGRAL_GAIN:     o_reg_rdata <= integral_gain_q;
                ADDR_SNR_THRESHOLD:     o_reg_rdata <= snr_threshold_q;
                ADDR_VCO_MEAS_LO:       o_reg_rdata <= vco_frequency_measure_q[7:0];
                ADDR_VCO_MEAS_HI:       o_reg_rdata <= vco_frequency_measure_q[15:8];
                ADDR_STATUS_FLAGS: begin
                    o_reg_rdata                     <= 8'h00;
                    o_reg_rdata[STAT_SNR_ABOVE]     <= snr_above_q; // [R6]
                    o_reg_rdata[STAT_VCO_MEAS_FULL] <= vco_full_q;
                end
                default:                o_reg_rdata <= 8'h00;
            endcase
        end else begin
            o_reg_rdata <= 8'h00;
        end
    end

    // ****************************************
    // VCO frequency measurement hold
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            vco_frequency_measure_q <= 16'h0000;
            vco_full_q              <= 1'b0;
            vco_read_q              <= 2'b00;
        end else if (!vco_full_q) begin
            if (i_vco_meas_valid) begin
                vco_frequency_measure_q <= i_vco_meas; // [R1]
                vco_full_q              <= 1'b1;
                vco_read_q              <= 2'b00;
            end
        end else if (i_reg_rd && i_reg_addr == ADDR_VCO_MEAS_LO) begin
            vco_read_q[0] <= 1'b1;
            vco_full_q    <= !vco_read_q[1]; // [R1]
        end else if (i_reg_rd && i_reg_addr == ADDR_VCO_MEAS_HI) begin
            vco_read_q[1] <= 1'b1;
            vco_full_q    <= !vco_read_q[0]; // [R1]
        end
    end

    // ****************************************
    // Phase error detector
    // ****************************************
    function automatic logic signed [15:0] sgn(input logic signed [SAMPLE_WIDTH-1:0] v);
        sgn = v[SAMPLE_WIDTH-1] ? -16'sd1 : 16'sd1;
    endfunction

    always_comb begin
        ped_err = 16'sd0;
        if (carrier_configuration_q[CFG_MODULATION_BPSK]) begin
            ped_err = sgn(sym.i_val) * 16'(sym.q_val); // [R4]
        end else if (carrier_configuration_q[CFG_ESTIMATOR_SELECT]) begin
            ped_err = (16'(sym.i_val) * 16'(sym.q_val)) >>> 3; // [R2] [R3]
        end else begin
            ped_err = sgn(sym.i_val) * 16'(sym.q_val)
                    - sgn(sym.q_val) * 16'(sym.i_val); // [R2] [R3]
        end
        ped_scaled = snr_above_q ? ped_err : (ped_err <<< 1); // [R5]
    end

    // ****************************************
    // SNR estimator
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            snr_acc_q   <= 16'h0000;
            snr_above_q <= 1'b0;
        end else if (sym_take) begin
            snr_acc_q <= snr_acc_q - (snr_acc_q >> SNR_SHIFT)
                       + {8'h00, 8'(sym.i_val[SAMPLE_WIDTH-1] ? -sym.i_val : sym.i_val)};
            snr_above_q <= snr_acc_q[15:8] > snr_threshold_q; // [R5]
        end
    end

    // ****************************************
    // Loop filter
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            integ_q <= 16'sd0;
            loop_q  <= 16'sd0;
        end else if (sym_take) begin
            integ_q <= integ_q + ((ped_scaled * $signed({8'h00, integral_gain_q})) >>> 8);
            loop_q  <= integ_q + ((ped_scaled * $signed({8'h00, proportional_gain_q})) >>> 6);
        end
    end

    assign loop_code = loop_q[15:10] ^ 6'h20;

    // ****************************************
    // Sigma-delta modulators
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            sd1_acc_q <= '0;
            sd2_acc_q <= '0;
            sd1_bit_q <= 1'b0;
            sd2_bit_q <= 1'b0;
        end else begin
            sd1_acc_q <= {1'b0, sd1_acc_q[PHASE_WIDTH-1:0]} + {1'b0, loop_code}; // [R10]
            sd2_acc_q <= {1'b0, sd2_acc_q[PHASE_WIDTH-1:0]} + {1'b0, loop_code}; // [R10]
            sd1_bit_q <= sd1_acc_q[PHASE_WIDTH];
            sd2_bit_q <= sd2_acc_q[PHASE_WIDTH];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_sd_out <= '{p1: 1'b0, n1: 1'b1, p2: 1'b0, n2: 1'b1}; // [R10]
            o_sd_oe  <= 2'b11; // [R12]
        end else begin
            o_sd_out <= '{p1: sd1_bit_q, n1: !sd1_bit_q, p2: sd2_bit_q, n2: !sd2_bit_q};
            o_sd_oe  <= {carrier_configuration_q[CFG_PAIR2_ENABLE],
                         carrier_configuration_q[CFG_PAIR1_ENABLE]}; // [R11]
        end
    end

    // ****************************************
    // Parallel phase output
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            dv_q                 <= 1'b0;
            o_data_valid         <= 1'b0;
            o_parallel_phase_out <= '0;
        end else begin
            dv_q         <= sym_take;
            o_data_valid <= dv_q;
            if (dv_q) begin
                o_parallel_phase_out <= loop_code; // [R13] [R16]
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_phase_hold;
        @(posedge i_mclk) disable iff (i_sys_rst)
        !o_data_valid |-> $stable(o_parallel_phase_out);
    endproperty
    a_phase_hold: assert property (p_phase_hold) else $error("phase out moved"); // [R16]

    property p_phase_dv;
        @(posedge i_mclk) disable iff (i_sys_rst)
        $fell(o_data_valid) |-> $stable(o_parallel_phase_out);
    endproperty
    a_phase_dv: assert property (p_phase_dv) else $error("phase unstable"); // [R15]

    property p_vco_hold;
        @(posedge i_mclk) disable iff (i_sys_rst)
        vco_full_q && !i_reg_rd |=> $stable(vco_frequency_measure_q) && vco_full_q;
    endproperty
    a_vco_hold: assert property (p_vco_hold) else $error("measure overwritten"); // [R1]

    property p_oe_cfg;
        @(posedge i_mclk) disable iff (i_sys_rst)
        ##1 o_sd_oe == {$past(carrier_configuration_q[CFG_PAIR2_ENABLE]),
                        $past(carrier_configuration_q[CFG_PAIR1_ENABLE])};
    endproperty
    a_oe_cfg: assert property (p_oe_cfg) else $error("pair enable wrong"); // [R11]

    property p_reset_oe;
        @(posedge i_mclk) $past(i_sys_rst) && !i_sys_rst |-> o_sd_oe == 2'b11;
    endproperty
    a_reset_oe: assert property (p_reset_oe) else $error("pairs not driven"); // [R12]

    property p_compl;
        @(posedge i_mclk) disable iff (i_sys_rst)
        o_sd_out.p1 != o_sd_out.n1 && o_sd_out.p2 != o_sd_out.n2;
    endproperty
    a_compl: assert property (p_compl) else $error("pair not complementary"); // [R10]

    property p_status;
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_reg_rd && i_reg_addr == ADDR_STATUS_FLAGS
        |=> o_reg_rdata[STAT_SNR_ABOVE] == $past(snr_above_q);
    endproperty
    a_status: assert property (p_status) else $error("status bit wrong"); // [R6]

    property p_bpsk;
        @(posedge i_mclk) disable iff (i_sys_rst)
        sym_take && carrier_configuration_q[CFG_MODULATION_BPSK]
        |-> ped_err == sgn(sym.i_val) * 16'(sym.q_val);
    endproperty
    a_bpsk: assert property (p_bpsk) else $error("bpsk estimator wrong"); // [R4]

    property p_phase_code;
        @(posedge i_mclk) disable iff (i_sys_rst)
        dv_q |=> o_parallel_phase_out == $past(loop_code);
    endproperty
    a_phase_code: assert property (p_phase_code) else $error("phase code wrong"); // [R13]

    property p_vco_release;
        @(posedge i_mclk) disable iff (i_sys_rst)
        vco_full_q && vco_read_q[0] && i_reg_rd && i_reg_addr == ADDR_VCO_MEAS_HI
        |=> !vco_full_q;
    endproperty
    a_vco_release: assert property (p_vco_release) else $error("measure not released"); // [R1]

    property p_status_full;
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_reg_rd && i_reg_addr == ADDR_STATUS_FLAGS
        |=> o_reg_rdata[STAT_VCO_MEAS_FULL] == $past(vco_full_q);
    endproperty
    a_status_full: assert property (p_status_full) else $error("full bit wrong"); // [R1]

    property p_thr_write;
        @(posedge i_mclk) disable iff (i_sys_rst)
        i_reg_wr && i_reg_addr == ADDR_SNR_THRESHOLD
        |=> snr_threshold_q == $past(i_reg_wdata);
    endproperty
    a_thr_write: assert property (p_thr_write) else $error("threshold not stored"); // [R5]

    property p_dv_latency;
        @(posedge i_mclk) disable iff (i_sys_rst)
        sym_take |-> ##2 o_data_valid;
    endproperty
    a_dv_latency: assert property (p_dv_latency) else $error("data valid late"); // [R13]

endmodule

// file: tb/loop_far_side_model.sv
`timescale 1ns/10ps
// ****************************************
// External DAC and VCO counter
// ****************************************
module loop_far_side_model
    import carrier_phase_pkg::*;
(
    // Clock and reset
    input  wire logic                   i_mclk,
    input  wire logic                   i_sys_rst,
    // Loop outputs
    input  wire sd_pairs_t              i_sd_out,
    input  wire logic [1:0]             i_sd_oe,
    input  wire logic [PHASE_WIDTH-1:0] i_phase,
    input  wire logic                   i_data_valid,
    // Measurement request
    input  wire logic                   i_meas_req,
    input  wire logic [15:0]            i_meas_val,
    output logic                        o_vco_meas_valid,
    output logic      [15:0]            o_vco_meas,
    // Observations
    output logic      [PHASE_WIDTH-1:0] o_dac_q,
    output int                          o_faults
);
    logic [PHASE_WIDTH-1:0] ph_q;

    initial begin
        o_vco_meas_valid = 1'b0;
        o_vco_meas       = 16'h0000;
        o_dac_q          = '0;
        o_faults         = 0;
        ph_q             = '0;
    end

    // Counter pulses a result; between pulses the bus toggles
    always @(posedge i_mclk) begin
        o_vco_meas_valid <= i_meas_req;
        o_vco_meas       <= i_meas_req ? i_meas_val : ~o_vco_meas;
    end

    // DAC clocked by the data valid strobe
    always @(posedge i_mclk) begin
        if (i_data_valid === 1'b1) begin
            o_dac_q <= i_phase;
        end
    end

    // Pair polarity and phase hold watch
    always @(posedge i_mclk) begin
        ph_q <= i_phase;
        if (i_sys_rst !== 1'b1) begin
            if (i_sd_oe[0] && i_sd_out.n1 !== ~i_sd_out.p1) o_faults <= o_faults + 1;
            if (i_sd_oe[1] && i_sd_out.n2 !== ~i_sd_out.p2) o_faults <= o_faults + 1;
            if (i_phase !== ph_q && i_data_valid !== 1'b1) o_faults <= o_faults + 1;
        end
    end
endmodule

// file: tb/carrier_phase_tracking_loop_tb.sv
`timescale 1ns/10ps
module carrier_phase_tracking_loop_tb
    import carrier_phase_pkg::*;
;
    logic                   i_mclk = 1'b0;
    logic                   i_sys_rst = 1'b1;
    logic [4:0]             i_reg_addr = 5'h00;
    logic [7:0]             i_reg_wdata = 8'h00;
    logic                   i_reg_wr = 1'b0;
    logic                   i_reg_rd = 1'b0;
    logic [7:0]             o_reg_rdata;
    logic                   i_sym_valid = 1'b0;
    logic                   o_sym_ready;
    symbol_t                i_sym = '0;
    logic                   vco_valid;
    logic [15:0]            vco_val;
    sd_pairs_t              o_sd_out;
    logic [1:0]             o_sd_oe;
    logic [PHASE_WIDTH-1:0] o_phase;
    logic                   o_data_valid;
    logic                   meas_req = 1'b0;
    logic [15:0]            meas_val = 16'h0000;
    logic [PHASE_WIDTH-1:0] dac_q;
    int                     faults;
    int                     miscompares = 0;
    int                     checks_done = 0;
    int                     cycles = 0;
    int                     dv_count = 0;
    logic [7:0]             rd;
    int                     dv_base;
    logic [7:0]             modes [4] = '{8'h30, 8'h34, 8'h70, 8'h74};

    // ****************************************
    // Clock, design and far side
    // ****************************************
    initial begin
        forever #4 i_mclk = ~i_mclk;
    end

    carrier_phase_tracking_loop dut (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .i_sym_valid(i_sym_valid), .o_sym_ready(o_sym_ready),
        .i_sym(i_sym), .i_vco_meas_valid(vco_valid), .i_vco_meas(vco_val),
        .o_sd_out(o_sd_out), .o_sd_oe(o_sd_oe), .o_parallel_phase_out(o_phase),
        .o_data_valid(o_data_valid)
    );

    loop_far_side_model far_side (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_sd_out(o_sd_out), .i_sd_oe(o_sd_oe),
        .i_phase(o_phase), .i_data_valid(o_data_valid), .i_meas_req(meas_req),
        .i_meas_val(meas_val), .o_vco_meas_valid(vco_valid), .o_vco_meas(vco_val),
        .o_dac_q(dac_q), .o_faults(faults)
    );

    // ****************************************
    // Tasks
    // ****************************************
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_mclk);
        i_reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [4:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_mclk);
        i_reg_rd <= 1'b0;
        #1 d = o_reg_rdata;
    endtask

    task automatic measure(input logic [15:0] v);
        @(posedge i_mclk);
        meas_req <= 1'b1;
        meas_val <= v;
        @(posedge i_mclk);
        meas_req <= 1'b0;
        repeat (3) @(posedge i_mclk);
    endtask

    task automatic send_syms(input int n, input logic signed [7:0] iv);
        int  sent;
        logic r;
        sent = 0;
        @(posedge i_mclk);
        i_sym <= '{i_val: iv, q_val: -iv};
        i_sym_valid <= 1'b1;
        while (sent < n) begin
            @(negedge i_mclk);
            r = o_sym_ready;
            @(posedge i_mclk);
            if (r === 1'b1) sent++;
        end
        i_sym_valid <= 1'b0;
        repeat (10) @(posedge i_mclk);
    endtask

    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (o_data_valid === 1'b1) dv_count <= dv_count + 1;
        if (cycles == 5000) begin
            miscompares++;
            summarize();
        end
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        #1 check_word({14'h0, o_sd_oe}, 16'h0003);
        reg_read(ADDR_CARRIER_CONFIG, rd);
        check_reg(rd, RST_CARRIER_CONFIG);
        reg_read(ADDR_PROPORTIONAL_GAIN, rd);
        check_reg(rd, RST_PROPORTIONAL_GAIN);
        reg_read(ADDR_INTEGRAL_GAIN, rd);
        check_reg(rd, RST_INTEGRAL_GAIN);
        reg_read(ADDR_SNR_THRESHOLD, rd);
        check_reg(rd, RST_SNR_THRESHOLD);
        reg_read(5'h05, rd);
        check_reg(rd, 8'h00);
        reg_write(ADDR_PROPORTIONAL_GAIN, 8'h0a);
        reg_write(ADDR_INTEGRAL_GAIN, 8'h1f);
        reg_write(ADDR_STATUS_FLAGS, 8'hff);
        reg_read(ADDR_PROPORTIONAL_GAIN, rd);
        check_reg(rd, 8'h0a);
        reg_read(ADDR_INTEGRAL_GAIN, rd);
        check_reg(rd, 8'h1f);
        reg_read(ADDR_STATUS_FLAGS, rd);
        check_reg(rd & 8'h11, 8'h00);
        for (int k = 0; k < 4; k++) begin
            reg_write(ADDR_CARRIER_CONFIG, 8'(k << 4));
            repeat (2) @(posedge i_mclk);
            check_word({14'h0, o_sd_oe}, 16'(k));
        end
        measure(16'h1234);
        measure(16'hbeef);
        reg_read(ADDR_VCO_MEAS_LO, rd);
        check_reg(rd, 8'h34);
        reg_read(ADDR_STATUS_FLAGS, rd);
        check_reg(rd & 8'h01, 8'h01);
        measure(16'hbeef);
        reg_read(ADDR_VCO_MEAS_HI, rd);
        check_reg(rd, 8'h12);
        reg_read(ADDR_STATUS_FLAGS, rd);
        check_reg(rd & 8'h01, 8'h00);
        measure(16'h5a0f);
        reg_read(ADDR_VCO_MEAS_HI, rd);
        check_reg(rd, 8'h5a);
        reg_read(ADDR_VCO_MEAS_LO, rd);
        check_reg(rd, 8'h0f);
        for (int m = 0; m < 4; m++) begin
            reg_write(ADDR_CARRIER_CONFIG, modes[m]);
            reg_write(ADDR_SNR_THRESHOLD, 8'h00);
            dv_base = dv_count;
            send_syms(40, 8'sd100);
            check_word(16'(dv_count - dv_base), 16'd40);
            reg_read(ADDR_STATUS_FLAGS, rd);
            check_reg(rd & 8'h10, 8'h10);
            reg_write(ADDR_SNR_THRESHOLD, 8'hff);
            send_syms(40, -8'sd100);
            reg_read(ADDR_STATUS_FLAGS, rd);
            check_reg(rd & 8'h10, 8'h00);
            check_word({10'h0, dac_q}, {10'h0, o_phase});
        end
        reg_write(ADDR_SNR_THRESHOLD, 8'h64);
        reg_read(ADDR_SNR_THRESHOLD, rd);
        check_reg(rd, 8'h64);
        check_word(16'(faults), 16'h0000);
        summarize();
    end
endmodule
